// file: ifp_pkg.sv
// Shared constants and types for the instruction fetch and program counter core
package ifp_pkg;
	localparam int PC_W = 12;
	localparam int PCL_W = 8;
	localparam int INSTR_W = 16;
	localparam int ALU_W = 8;
	localparam int AXI_AW = 8;
	localparam int STACK_LEVELS = 8;
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [11:0] IRQ_VECTOR = 12'h004;
	localparam logic [7:0] OFF_PCL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
	localparam int ST_PC_LSB = 0;
	localparam int ST_SP_LSB = 12;
	localparam int ST_DEPTH_LSB = 16;
	localparam int ST_EXEC_BIT = 20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0]
	{
		PH_T1 = 4'h1,
		PH_T2 = 4'h2,
		PH_T3 = 4'h4,
		PH_T4 = 4'h8
	} ifp_phase_t;

	typedef enum logic [2:0]
	{
		ALU_ADD = 3'h0,
		ALU_SUB = 3'h1,
		ALU_AND = 3'h2,
		ALU_OR = 3'h3,
		ALU_XOR = 3'h4,
		ALU_INC = 3'h5,
		ALU_DEC = 3'h6,
		ALU_PASS = 3'h7
	} ifp_alu_op_t;

	typedef struct packed
	{
		logic jump;
		logic call;
		logic ret;
		logic extended;
		logic skip_zero;
		logic skip_nonzero;
		logic [11:0] target;
	} ifp_flow_t;

	typedef struct packed
	{
		ifp_alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} ifp_alu_req_t;
endpackage

// file: ifp_core.sv
// Four-phase instruction sequencer, program counter, return stack and register slave
`timescale 1ns/10ps
module ifp_core #(
	parameter int STACK_LEVELS = ifp_pkg::STACK_LEVELS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite register slave
	input wire logic [ifp_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ifp_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Program memory
	output logic [ifp_pkg::PC_W-1:0] pm_addr,
	input wire logic [ifp_pkg::INSTR_W-1:0] pm_rdata,
	// Phase outputs
	output logic [3:0] instruction_phase_clocks,
	// Decode and execute datapath
	output logic [ifp_pkg::INSTR_W-1:0] exec_instr,
	output logic [ifp_pkg::PC_W-1:0] exec_addr,
	output logic exec_valid,
	input wire ifp_pkg::ifp_flow_t flow_in,
	input wire ifp_pkg::ifp_alu_req_t alu_req,
	output logic [ifp_pkg::ALU_W-1:0] alu_result,
	output logic alu_zero,
	// Interrupt request and acknowledge
	input wire logic irq_req,
	output logic irq_ack
);
	localparam int SP_W = $clog2(STACK_LEVELS);

	if (STACK_LEVELS < 2 || STACK_LEVELS > 8 || (1 << SP_W) != STACK_LEVELS)
	begin : g_bad_levels
		$error("STACK_LEVELS must be a power of two from 2 to 8");
	end

	// Phase sequencer
	ifp_pkg::ifp_phase_t phase_reg, phase_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic run;
	logic at_t1, at_t3, at_t4;

	assign run = ctrl_reg[ifp_pkg::CTRL_RUN_BIT];
	assign at_t1 = run && (phase_reg == ifp_pkg::PH_T1);
	assign at_t3 = run && (phase_reg == ifp_pkg::PH_T3);
	assign at_t4 = run && (phase_reg == ifp_pkg::PH_T4);
	// One-hot and registered, so two phases are never high together
	assign instruction_phase_clocks = phase_reg;

	always_comb
	begin
		phase_next = phase_reg;
		if (run)
		begin
			unique case (phase_reg)
				ifp_pkg::PH_T1: phase_next = ifp_pkg::PH_T2;
				ifp_pkg::PH_T2: phase_next = ifp_pkg::PH_T3;
				ifp_pkg::PH_T3: phase_next = ifp_pkg::PH_T4;
				ifp_pkg::PH_T4: phase_next = ifp_pkg::PH_T1;
				default: phase_next = ifp_pkg::PH_T1;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase_reg <= ifp_pkg::PH_T1;
		else
			phase_reg <= phase_next;
	end

	// Eight-bit unit; result settles by the end of the third phase
	logic [7:0] alu_result_reg, alu_result_next;
	logic alu_zero_reg, alu_zero_next;

	always_comb
	begin
		alu_result_next = alu_result_reg;
		alu_zero_next = alu_zero_reg;
		if (at_t3)
		begin
			unique case (alu_req.op)
				ifp_pkg::ALU_ADD: alu_result_next = alu_req.a + alu_req.b;
				ifp_pkg::ALU_SUB: alu_result_next = alu_req.a - alu_req.b;
				ifp_pkg::ALU_AND: alu_result_next = alu_req.a & alu_req.b;
				ifp_pkg::ALU_OR: alu_result_next = alu_req.a | alu_req.b;
				ifp_pkg::ALU_XOR: alu_result_next = alu_req.a ^ alu_req.b;
				ifp_pkg::ALU_INC: alu_result_next = alu_req.a + 8'h01;
				ifp_pkg::ALU_DEC: alu_result_next = alu_req.a - 8'h01;
				ifp_pkg::ALU_PASS: alu_result_next = alu_req.a;
			endcase
			alu_zero_next = (alu_result_next == 8'h00);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alu_result_reg <= 8'h00;
			alu_zero_reg <= 1'b0;
		end
		else
		begin
			alu_result_reg <= alu_result_next;
			alu_zero_reg <= alu_zero_next;
		end
	end

	assign alu_result = alu_result_reg;
	assign alu_zero = alu_zero_reg;

	// Program counter, pipeline and return stack
	logic [11:0] pc_reg, pc_next;
	logic [15:0] fetch_word_reg, fetch_word_next;
	logic [15:0] exec_word_reg, exec_word_next;
	logic [11:0] exec_addr_reg, exec_addr_next;
	logic exec_valid_reg, exec_valid_next;
	logic ext_second_reg, ext_second_next;
	logic pcl_pend_reg, pcl_pend_next;
	logic [7:0] pcl_data_reg, pcl_data_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [SP_W:0] depth_reg, depth_next;
	logic irq_ack_reg, irq_ack_next;
	logic [11:0] stack_mem [STACK_LEVELS];
	logic push;
	logic redirect;
	logic skip_true;
	logic pcl_wr;
	logic [7:0] pcl_wdata;

	assign skip_true = (flow_in.skip_zero && alu_zero_reg) || (flow_in.skip_nonzero && !alu_zero_reg);

	always_comb
	begin
		pc_next = pc_reg;
		fetch_word_next = fetch_word_reg;
		exec_word_next = exec_word_reg;
		exec_addr_next = exec_addr_reg;
		exec_valid_next = exec_valid_reg;
		ext_second_next = ext_second_reg;
		pcl_pend_next = pcl_pend_reg;
		pcl_data_next = pcl_data_reg;
		sp_next = sp_reg;
		depth_next = depth_reg;
		irq_ack_next = 1'b0;
		push = 1'b0;
		redirect = 1'b0;
		if (at_t1)
			fetch_word_next = pm_rdata;
		if (at_t4 && exec_valid_reg && flow_in.extended && !ext_second_reg)
			ext_second_next = 1'b1;
		else if (at_t4)
		begin
			ext_second_next = 1'b0;
			pc_next = pc_reg + 12'h001;
			if (exec_valid_reg && flow_in.ret)
			begin
				redirect = 1'b1;
				sp_next = sp_reg - 1'b1;
				pc_next = stack_mem[sp_next];
				if (depth_reg != '0)
					depth_next = depth_reg - 1'b1;
			end
			else if (exec_valid_reg && (flow_in.jump || flow_in.call))
			begin
				redirect = 1'b1;
				pc_next = flow_in.target;
				push = flow_in.call;
			end
			else if (pcl_pend_reg)
			begin
				redirect = 1'b1;
				pcl_pend_next = 1'b0;
				pc_next = {pc_reg[11:8], pcl_data_reg};
			end
			else if (exec_valid_reg && skip_true)
				redirect = 1'b1;
			// A full stack holds the request off until a return frees a level
			if (!redirect && irq_req && (depth_reg < (SP_W+1)'(STACK_LEVELS)))
			begin
				redirect = 1'b1;
				push = 1'b1;
				pc_next = ifp_pkg::IRQ_VECTOR;
				irq_ack_next = 1'b1;
			end
			if (push)
			begin
				sp_next = sp_reg + 1'b1;
				if (depth_reg < (SP_W+1)'(STACK_LEVELS))
					depth_next = depth_reg + 1'b1;
			end
			exec_word_next = fetch_word_reg;
			exec_addr_next = pc_reg;
			exec_valid_next = !redirect;
		end
		// A fresh write wins over the clear of the previous one
		if (pcl_wr)
		begin
			pcl_pend_next = 1'b1;
			pcl_data_next = pcl_wdata;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc_reg <= ifp_pkg::RESET_VECTOR;
			fetch_word_reg <= 16'h0000;
			exec_word_reg <= 16'h0000;
			exec_addr_reg <= 12'h000;
			exec_valid_reg <= 1'b0;
			ext_second_reg <= 1'b0;
			pcl_pend_reg <= 1'b0;
			pcl_data_reg <= 8'h00;
			sp_reg <= '0;
			depth_reg <= '0;
			irq_ack_reg <= 1'b0;
		end
		else
		begin
			pc_reg <= pc_next;
			fetch_word_reg <= fetch_word_next;
			exec_word_reg <= exec_word_next;
			exec_addr_reg <= exec_addr_next;
			exec_valid_reg <= exec_valid_next;
			ext_second_reg <= ext_second_next;
			pcl_pend_reg <= pcl_pend_next;
			pcl_data_reg <= pcl_data_next;
			sp_reg <= sp_next;
			depth_reg <= depth_next;
			irq_ack_reg <= irq_ack_next;
		end
	end

	// Overflowing calls overwrite the oldest level, as the pointer wraps
	always_ff @(posedge aclk)
	begin
		if (push)
			stack_mem[sp_reg] <= pc_reg;
	end

	assign pm_addr = pc_reg;
	assign exec_instr = exec_word_reg;
	assign exec_addr = exec_addr_reg;
	assign exec_valid = exec_valid_reg;
	assign irq_ack = irq_ack_reg;

	// AXI4-Lite slave: one write and one read in flight
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire;
	logic [31:0] status_word;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
	assign pcl_wr = wr_fire && wstrb0_reg && (awaddr_reg == ifp_pkg::OFF_PCL);
	assign pcl_wdata = wdata_reg[7:0];

	always_comb
	begin
		status_word = 32'h00000000;
		status_word[ifp_pkg::ST_PC_LSB +: 12] = pc_reg;
		status_word[ifp_pkg::ST_SP_LSB +: SP_W] = sp_reg;
		status_word[ifp_pkg::ST_DEPTH_LSB +: SP_W+1] = depth_reg;
		status_word[ifp_pkg::ST_EXEC_BIT] = exec_valid_reg;
	end

	always_comb
	begin
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb0_next = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_next = 1'b0;
		if (wr_fire)
		begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = ifp_pkg::RESP_OKAY;
			if (awaddr_reg == ifp_pkg::OFF_CTRL && wstrb0_reg)
				ctrl_next[ifp_pkg::CTRL_RUN_BIT] = wdata_reg[ifp_pkg::CTRL_RUN_BIT];
			else if (awaddr_reg != ifp_pkg::OFF_CTRL && awaddr_reg != ifp_pkg::OFF_PCL
				&& awaddr_reg != ifp_pkg::OFF_STATUS)
				bresp_next = ifp_pkg::RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready)
			rvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next = ifp_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				ifp_pkg::OFF_PCL: rdata_next = {24'h000000, pc_reg[7:0]};
				ifp_pkg::OFF_STATUS: rdata_next = status_word;
				ifp_pkg::OFF_CTRL: rdata_next = ctrl_reg;
				default:
				begin
					rdata_next = 32'h00000000;
					rresp_next = ifp_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h00000000;
			ctrl_reg <= ifp_pkg::CTRL_RESET;
		end
		else
		begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
endmodule // ifp_core

// file: ifp_pmem_model.sv
// Program memory model answering each fetch address
`timescale 1ns/10ps
module ifp_pmem_model (
	// Fetch port
	input wire logic [11:0] pm_addr,
	output logic [15:0] pm_rdata
);
	// Word carries its own address so a wrong fetch shows up in exec_instr
	assign pm_rdata = {4'hC, pm_addr};
endmodule // ifp_pmem_model

// file: ifp_core_props.sv
// Concurrent checks on the core's pins
`timescale 1ns/10ps
module ifp_core_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Pipeline
	input wire logic [11:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	input wire logic [3:0] instruction_phase_clocks,
	input wire logic [15:0] exec_instr,
	input wire logic [11:0] exec_addr,
	input wire logic exec_valid,
	input wire ifp_pkg::ifp_flow_t flow_in,
	input wire ifp_pkg::ifp_alu_req_t alu_req,
	input wire logic [7:0] alu_result,
	input wire logic alu_zero,
	input wire logic irq_req,
	input wire logic irq_ack
);
	logic [3:0] quiet_reg;
	logic [3:0] quiet_next;
	wire logic [3:0] ph = instruction_phase_clocks;
	wire logic [3:0] rot = {ph[2:0], ph[3]};
	wire logic calm = quiet_reg == 4'hF && flow_in[17:12] == 6'h00;
	// A posted low-byte write redirects later, so sequential checks wait it out
	always_comb
	begin
		quiet_next = quiet_reg + {3'h0, quiet_reg != 4'hF};
		if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00)
			quiet_next = 4'h0;
	end
	always_ff @(posedge aclk)
		quiet_reg <= aresetn ? quiet_next : 4'h0;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_reset_start: assert property ($rose(aresetn) |-> ph == 4'h1 && pm_addr == 12'h000 && !exec_valid)
		else $error("bad start state");
	chk_phase_order: assert property ($onehot(ph) && (ph == $past(ph) || ph == $past(rot)))
		else $error("bad phase order");
	chk_fetch_hold: assert property (!ph[0] |-> $stable(pm_addr))
		else $error("fetch address moved");
	chk_seq_step: assert property (ph[3] && exec_valid && calm && !irq_req |=> pm_addr == $past(pm_addr) + 12'h001
		&& exec_valid && exec_addr == $past(pm_addr) && exec_instr == $past(pm_rdata))
		else $error("bad sequential step");
	chk_branch_two: assert property (ph[3] && exec_valid && flow_in[17:16] != 2'h0 && flow_in[15:14] == 2'h0
		|=> pm_addr == $past(flow_in.target) ##0 !exec_valid [*4] ##1 exec_addr == $past(flow_in.target, 5) && exec_valid)
		else $error("bad branch timing");
	chk_skip_drop: assert property (ph[3] && exec_valid && flow_in.skip_zero && alu_zero && flow_in[17:14] == 4'h0
		&& quiet_reg == 4'hF |=> pm_addr == $past(pm_addr) + 12'h001 && !exec_valid)
		else $error("bad skip");
	chk_irq_entry: assert property (ph[3] && exec_valid && calm && irq_req
		|=> irq_ack && pm_addr == ifp_pkg::IRQ_VECTOR && !exec_valid)
		else $error("bad interrupt entry");
	chk_pcl_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
		|=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(pm_addr[7:0])})
		else $error("bad low byte read");
	chk_alu_add: assert property (ph[2] && alu_req.op == ifp_pkg::ALU_ADD
		|=> alu_result == $past(alu_req.a) + $past(alu_req.b) && alu_zero == (alu_result == 8'h00))
		else $error("bad alu sum");
endmodule // ifp_core_props

// file: test_ifp_core.sv
// Self-checking bench for the instruction fetch core
`timescale 1ns/10ps
module test_ifp_core;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, irq_req = 1'b0, hold = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_valid, alu_zero, irq_ack;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, alu_result, d8;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1, instruction_phase_clocks;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] pm_addr, exec_addr, t, q;
	logic [15:0] pm_rdata, exec_instr;
	ifp_pkg::ifp_flow_t flow_in = '0;
	ifp_pkg::ifp_alu_req_t alu_req = '0;
	logic [33:0] exp_q[$];
	int mismatches = 0, checks = 0;
	initial
		forever #20 aclk = ~aclk;
	ifp_core ifp_core_i (.*);
	ifp_pmem_model ifp_pmem_model_i (.*);
	task automatic final_report;
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write notes carry the expected response in their top two bits
	task automatic cmp_resp(input logic [1:0] got, input logic [33:0] note);
		checks++;
		if (got !== note[33:32])
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, note[33:32]);
		end
	endtask
	task automatic step(inout int n);
		@(posedge aclk);
		n++;
		if (n > 60)
		begin
			mismatches++;
			final_report;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n = 0;
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do step(n); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do step(n); while (!s_axi_rvalid);
	endtask
	// Each channel is released at the edge that takes it, whatever the other does
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		logic aw_done = 1'b0;
		logic w_done = 1'b0;
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			step(n);
			if (!aw_done && s_axi_awready)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do step(n); while (!s_axi_bvalid);
	endtask
	// Flow word stands through the fourth phase of the next executing cycle only
	task automatic flow(input logic [17:0] f);
		int n = 0;
		do step(n); while (!(instruction_phase_clocks[2] && exec_valid));
		flow_in <= f;
		step(n);
		flow_in <= '0;
	endtask
	function automatic logic [33:0] st(input logic v, input logic [3:0] d, input logic [2:0] s, input logic [11:0] a);
		return {13'h0, v, d, 1'b0, s, a};
	endfunction
	function automatic logic [33:0] program_counter_low_byte(input logic [11:0] a);
		return {26'h0, a[7:0]};
	endfunction
	always @(posedge aclk)
		alu_req <= {hold ? 3'h2 : 3'($urandom), 8'($urandom), hold ? 8'h00 : 8'($urandom)};
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			cmp_read({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		else if (s_axi_bvalid && s_axi_bready)
			cmp_resp(s_axi_bresp, exp_q.pop_front());
	initial
	begin
		void'($urandom(32'h55645415));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00, 34'h0);
		rd(8'h0C, {2'h2, 32'h0});
		t = 12'($urandom);
		flow({6'h20, t});
		rd(8'h00, program_counter_low_byte(t));
		rd(8'h04, st(1'b0, 4'h0, 3'h0, t));
		flow({6'h10, t + 12'h100});
		rd(8'h04, st(1'b0, 4'h1, 3'h1, t + 12'h100));
		flow({6'h08, 12'h0});
		rd(8'h00, program_counter_low_byte(t + 12'h001));
		hold <= 1'b1;
		flow({6'h02, 12'h0});
		rd(8'h04, st(1'b0, 4'h0, 3'h0, t + 12'h003));
		flow({6'h01, 12'h0});
		rd(8'h04, st(1'b1, 4'h0, 3'h0, t + 12'h005));
		hold <= 1'b0;
		flow(18'h0);
		d8 = 8'($urandom);
		q = t + 12'h006;
		q[7:0] = d8;
		wr(8'h00, {24'h0, d8}, 2'h0);
		rd(8'h04, st(1'b1, 4'h0, 3'h0, t + 12'h006));
		rd(8'h00, program_counter_low_byte(q));
		rd(8'h04, st(1'b0, 4'h0, 3'h0, q));
		flow({6'h04, 12'h0});
		rd(8'h04, st(1'b1, 4'h0, 3'h0, q + 12'h001));
		flow(18'h0);
		rd(8'h04, st(1'b1, 4'h0, 3'h0, q + 12'h002));
		irq_req <= 1'b1;
		flow(18'h0);
		irq_req <= 1'b0;
		rd(8'h04, st(1'b0, 4'h1, 3'h1, ifp_pkg::IRQ_VECTOR));
		flow({6'h08, 12'h0});
		rd(8'h00, program_counter_low_byte(q + 12'h002));
		wr(8'h0C, 32'h0, 2'h2);
		wr(8'h04, 32'h0, 2'h0);
		s_axi_wstrb <= 4'h0;
		wr(8'h08, 32'h0, 2'h0);
		s_axi_wstrb <= 4'h1;
		rd(8'h08, {2'h0, ifp_pkg::CTRL_RESET});
		repeat (2) @(posedge aclk);
		if (exp_q.size() != 0)
			mismatches++;
		final_report;
	end
endmodule // test_ifp_core
bind ifp_core ifp_core_props ifp_core_props_i (.*);
